// [itc_pkg.sv]
package itc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] OFS_COMPARE_PERIOD = 8'h1C;
    localparam logic [7:0] OFS_COUNT_CAPTURE  = 8'h1D;
    localparam logic [7:0] OFS_TIMER_CONTROL  = 8'h1E;
    localparam logic [7:0] OFS_IRQ_STATUS     = 8'h1F;
    localparam logic [7:0] OFS_IRQ_MASK       = 8'h20;
    localparam logic [7:0] OFS_CLOCK_CONFIG   = 8'h21;

    ////////////////////////////////////////////////////////////////////////
    // Timer control, clock config and interrupt field positions
    localparam int CTL_MODE_BIT  = 0;
    localparam int CTL_SEL_LSB   = 1;
    localparam int CTL_SEL_MSB   = 3;
    localparam int CTL_RUN_BIT   = 4;
    localparam int CTL_AUTO_CAPTURE_ENABLE_BIT  = 6;
    localparam int CFG_DIV_BIT   = 0;
    localparam int IRQ_MATCH_BIT = 0;
    localparam int IRQ_W         = 1;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [7:0] RST_COMPARE = 8'hFF;
    localparam logic [7:0] RST_CAPTURE = 8'hFF;
    localparam logic [7:0] RST_CONTROL = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Source clock selection
    localparam logic [2:0] SEL_RESERVED = 3'h7;
    localparam int         DIV_LOG2_MAX = 13;
    localparam int         PRE_W        = 14;

    typedef enum logic
    {
        ITC_MODE_TIMER,
        ITC_MODE_RESERVED
    } itc_mode_t;

endpackage

// [itc_prescaler.sv]
`timescale 1ns/1ps
module itc_prescaler
    import itc_pkg::*;
#(
    parameter int W = PRE_W
)
(
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_ce,
    input  wire logic       i_clr,
    input  wire logic [2:0] i_sel,
    input  wire logic       i_div,
    output logic            o_tick
);
    logic [W-1:0] div_reg;
    logic [W-1:0] span_mask;
    logic [4:0]   shift;

    ////////////////////////////////////////////////////////////////////////
    // Held in reset while stopped, so the first tick after a start comes
    // a full period later instead of at a random phase.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            div_reg <= '0;
        else if (i_ce)
        begin
            if (i_clr)
                div_reg <= '0;
            else
                div_reg <= div_reg + {{(W-1){1'b0}}, 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Code 0 divides by 2^13, each step halves, the divider bit doubles
    always_comb
    begin
        shift     = 5'(DIV_LOG2_MAX) - {2'b00, i_sel} + {4'b0000, i_div};
        span_mask = W'((W+1)'(1) << shift) - {{(W-1){1'b0}}, 1'b1};
    end

    assign o_tick = i_ce && !i_clr && (i_sel != SEL_RESERVED)
                    && (&(div_reg | ~span_mask));  // [RULE5]

endmodule // itc_prescaler

// [itc_irq.sv]
`timescale 1ns/1ps
module itc_irq
    import itc_pkg::*;
#(
    parameter int W = IRQ_W
)
(
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_set,
    input  wire logic         i_rd_clr,
    input  wire logic         i_mask_we,
    input  wire logic [W-1:0] i_mask_wdata,
    output logic      [W-1:0] o_status,
    output logic      [W-1:0] o_mask,
    output logic              o_irq
);
    logic [W-1:0] status_reg;
    logic [W-1:0] mask_reg;

    ////////////////////////////////////////////////////////////////////////
    // Sticky status; an event in the clearing cycle survives the read
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            always_ff @(posedge i_clk or negedge i_nrst)
            begin
                if (!i_nrst)
                    status_reg[g] <= 1'b0;
                else if (i_ce)
                begin
                    if (i_set[g])
                        status_reg[g] <= 1'b1;
                    else if (i_rd_clr)
                        status_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            mask_reg <= '0;
        else if (i_ce && i_mask_we)
            mask_reg <= i_mask_wdata;
    end

    assign o_status = status_reg;
    assign o_mask   = mask_reg;
    assign o_irq    = |(status_reg & mask_reg);

endmodule // itc_irq

// [itc_timer.sv]
//
// Notes on behaviour
// RULE1 - Eight-bit compare and capture registers beside an eight-bit up-counter.
// RULE2 - Timer mode: counter steps once per selected source tick while running.
// RULE3 - Count equal to compare: raise interrupt, clear counter, keep counting.
// RULE4 - Run bit 0 stops and clears counter; run bit 1 starts counting.
// RULE5 - Select codes 0..6 give divide 2^13..2^7; divider bit doubles the divide; 7 reserved.
// RULE6 - Mode bit 0 is timer mode; value 1 is reserved.
// RULE7 - With auto-capture set, counter value is copied to the capture register.
// RULE8 - The zero after a match is not captured; old capture value stays.
// RULE9 - Reading capture while running returns the current captured count.
// RULE10 - Software changes source select only while stopped.
// RULE11 - Software programs compare values above one.
// RULE12 - Software does not write compare while running.
// RULE13 - Control bits 5 and 7 read as undefined; software ignores them.
// RULE14 - Capture register is read-only and resets to all ones.
// RULE15 - Control fields reset to zero: stopped, timer mode, slowest clock.
// RULE16 - A new compare value takes effect at the next source tick.
// RULE17 - Capture updates each non-match tick; match gives a one-cycle match pulse and sets the sticky interrupt status.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module itc_timer
    import itc_pkg::*;
(
    input  wire logic                      I_CLK,
    input  wire logic                      I_NRST,
    input  wire logic                      I_CE,
    input  wire logic [itc_pkg::ADDR_W-1:0] I_ADDR,
    input  wire logic [itc_pkg::DATA_W-1:0] I_WDATA,
    input  wire logic                      I_WR,
    input  wire logic                      I_RD,
    output logic      [itc_pkg::DATA_W-1:0] O_RDATA,
    output logic                           O_MATCH,
    output logic                           O_IRQ
);
    logic [7:0]      compare_period_reg;
    logic [7:0]      count_capture_reg;
    logic [7:0]      count_reg;
    logic [7:0]      count_next;
    logic [7:0]      rdata_reg;
    logic [7:0]      rdata_next;
    logic            match_reg;
    logic            run_control_reg;
    logic            auto_capture_enable_reg;
    logic [2:0]      source_clock_select_reg;
    itc_mode_t       operating_mode_select_reg;
    logic            divider_stage_select_reg;
    logic            tick;
    logic            counting;
    logic            hit;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic            wr_cmp;
    logic            wr_ctl;
    logic            wr_cfg;
    logic            wr_msk;
    logic            rd_sts;

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    assign wr_cmp = I_CE && I_WR && (I_ADDR == OFS_COMPARE_PERIOD);
    assign wr_ctl = I_CE && I_WR && (I_ADDR == OFS_TIMER_CONTROL);
    assign wr_cfg = I_CE && I_WR && (I_ADDR == OFS_CLOCK_CONFIG);
    assign wr_msk = I_CE && I_WR && (I_ADDR == OFS_IRQ_MASK);
    assign rd_sts = I_CE && I_RD && (I_ADDR == OFS_IRQ_STATUS);

    ////////////////////////////////////////////////////////////////////////
    // Compare register; no shadow is needed because the value is only
    // looked at on source ticks, so a write lands at the next tick
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
            compare_period_reg <= RST_COMPARE;
        else if (wr_cmp)
            compare_period_reg <= I_WDATA;  // [RULE1] [RULE12]
    end

    ////////////////////////////////////////////////////////////////////////
    // Control fields
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            run_control_reg           <= RST_CONTROL[CTL_RUN_BIT];  // [RULE15]
            auto_capture_enable_reg   <= RST_CONTROL[CTL_AUTO_CAPTURE_ENABLE_BIT];
            source_clock_select_reg   <= RST_CONTROL[CTL_SEL_MSB:CTL_SEL_LSB];
            operating_mode_select_reg <= ITC_MODE_TIMER;
        end
        else if (wr_ctl)
        begin
            run_control_reg           <= I_WDATA[CTL_RUN_BIT];  // [RULE4]
            auto_capture_enable_reg   <= I_WDATA[CTL_AUTO_CAPTURE_ENABLE_BIT];
            // Changing the select while running is left to software care
            source_clock_select_reg   <= I_WDATA[CTL_SEL_MSB:CTL_SEL_LSB];
            operating_mode_select_reg <= itc_mode_t'(I_WDATA[CTL_MODE_BIT]);
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
            divider_stage_select_reg <= 1'b0;
        else if (wr_cfg)
            divider_stage_select_reg <= I_WDATA[CFG_DIV_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // Source clock
    itc_prescaler #(
        .W      (PRE_W)
    ) u_prescaler (
        .i_clk  (I_CLK),
        .i_nrst (I_NRST),
        .i_ce   (I_CE),
        .i_clr  (!run_control_reg),
        .i_sel  (source_clock_select_reg),
        .i_div  (divider_stage_select_reg),
        .o_tick (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Up-counter. The reserved mode simply holds the count.
    assign counting = run_control_reg
                      && (operating_mode_select_reg == ITC_MODE_TIMER);  // [RULE6]
    assign count_next = count_reg + 8'h01;
    assign hit = tick && counting
                 && (count_next == compare_period_reg);  // [RULE3] [RULE16]

    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
            count_reg <= 8'h00;
        else if (I_CE)
        begin
            if (!run_control_reg)
                count_reg <= 8'h00;  // [RULE4]
            else if (hit)
                count_reg <= 8'h00;  // [RULE3]
            else if (tick && counting)
                count_reg <= count_next;  // [RULE2]
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
            match_reg <= 1'b0;
        else if (I_CE)
            match_reg <= hit;  // [RULE17]
    end

    ////////////////////////////////////////////////////////////////////////
    // Auto-capture tracks the count on each tick but skips the post-match
    // zero, so software reading it never sees a spurious wrap to 0
    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
            count_capture_reg <= RST_CAPTURE;  // [RULE14]
        else if (I_CE && tick && counting && auto_capture_enable_reg && !hit)
            count_capture_reg <= count_next;  // [RULE7] [RULE8] [RULE17]
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask
    itc_irq #(
        .W            (IRQ_W)
    ) u_irq (
        .i_clk        (I_CLK),
        .i_nrst       (I_NRST),
        .i_ce         (I_CE),
        .i_set        (hit),
        .i_rd_clr     (rd_sts),
        .i_mask_we    (wr_msk),
        .i_mask_wdata (I_WDATA[IRQ_W-1:0]),
        .o_status     (irq_status),
        .o_mask       (irq_mask),
        .o_irq        (O_IRQ)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read path: data stand one cycle after an enabled strobe, zero after other enabled cycles, held while I_CE is low
    always_comb
    begin
        rdata_next = 8'h00;
        unique case (I_ADDR)
            OFS_COMPARE_PERIOD: rdata_next = compare_period_reg;
            OFS_COUNT_CAPTURE:  rdata_next = count_capture_reg;  // [RULE9]
            OFS_TIMER_CONTROL:  // Bits 5 and 7 read as zero  [RULE13]
            begin
                rdata_next[CTL_AUTO_CAPTURE_ENABLE_BIT] = auto_capture_enable_reg;
                rdata_next[CTL_RUN_BIT]  = run_control_reg;
                rdata_next[CTL_SEL_MSB:CTL_SEL_LSB] = source_clock_select_reg;
                rdata_next[CTL_MODE_BIT] = operating_mode_select_reg;
            end
            OFS_IRQ_STATUS:     rdata_next[IRQ_W-1:0] = irq_status;
            OFS_IRQ_MASK:       rdata_next[IRQ_W-1:0] = irq_mask;
            OFS_CLOCK_CONFIG:   rdata_next[CFG_DIV_BIT] = divider_stage_select_reg;
            default:            rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
            rdata_reg <= 8'h00;
        else if (I_CE)
            rdata_reg <= I_RD ? rdata_next : 8'h00;
    end

    assign O_RDATA = rdata_reg;
    assign O_MATCH = match_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_NRST);

    stop_clears_a: assert property ( // [RULE4]
        (I_CE && !run_control_reg) |=> (count_reg == 8'h00))
        else $error("counter not cleared while stopped");

    match_clears_a: assert property ( // [RULE3]
        (I_CE && hit) |=> (count_reg == 8'h00) && O_MATCH)
        else $error("match did not clear counter and pulse");

    match_pulse_a: assert property ( // [RULE17]
        (I_CE && O_MATCH) |=> !O_MATCH)
        else $error("match pulse longer than one cycle");

    count_step_a: assert property ( // [RULE2]
        (I_CE && tick && counting && !hit)
        |=> (count_reg == $past(count_reg) + 8'h01))
        else $error("counter did not step on tick");

    no_tick_hold_a: assert property ( // [RULE2]
        (I_CE && !tick && run_control_reg) |=> $stable(count_reg))
        else $error("counter moved without a tick");

    reserved_mode_a: assert property ( // [RULE6]
        (I_CE && operating_mode_select_reg == ITC_MODE_RESERVED)
        |=> (count_reg == $past(count_reg)) || (count_reg == 8'h00))
        else $error("counter advanced in reserved mode");

    capture_follow_a: assert property ( // [RULE7]
        (I_CE && tick && counting && auto_capture_enable_reg && !hit)
        |=> (count_capture_reg == count_reg))
        else $error("capture did not follow the count");

    capture_skip_a: assert property ( // [RULE8]
        (I_CE && hit) |=> $stable(count_capture_reg))
        else $error("post-match zero was captured");

    capture_read_a: assert property ( // [RULE9]
        (I_CE && I_RD && I_ADDR == OFS_COUNT_CAPTURE)
        |=> (O_RDATA == $past(count_capture_reg)))
        else $error("capture read returned wrong value");

    ctrl_bits_a: assert property ( // [RULE13]
        (I_CE && I_RD && I_ADDR == OFS_TIMER_CONTROL)
        |=> (O_RDATA[7] == 1'b0) && (O_RDATA[5] == 1'b0))
        else $error("control bits 5 or 7 not zero");

    irq_raise_a: assert property ( // [RULE17]
        (O_MATCH && irq_mask[IRQ_MATCH_BIT]) |-> O_IRQ)
        else $error("unmasked match did not raise interrupt");

    ////////////////////////////////////////////////////////////////////////
    // Source clock, register and status checks
    rsv_sel_a: assert property ( // [RULE5]
        (source_clock_select_reg == SEL_RESERVED) |-> !tick)
        else $error("tick from reserved select code");

    tick_run_a: assert property ( // [RULE5]
        tick |-> (I_CE && run_control_reg))
        else $error("tick while stopped or frozen");

    no_match_a: assert property ( // [RULE17]
        (I_CE && !hit) |=> !O_MATCH)
        else $error("match pulse without a hit");

    ce_freeze_a: assert property ( // [RULE2]
        !I_CE |=> $stable(count_reg) && $stable(O_RDATA))
        else $error("state moved while clock enable low");

    capture_hold_a: assert property ( // [RULE14]
        !(I_CE && tick && counting && auto_capture_enable_reg)
        |=> $stable(count_capture_reg))
        else $error("capture changed without a capture tick");

    cmp_write_a: assert property ( // [RULE1]
        wr_cmp |=> (compare_period_reg == $past(I_WDATA)))
        else $error("compare write did not land");

    cmp_hold_a: assert property ( // [RULE1]
        !wr_cmp |=> $stable(compare_period_reg))
        else $error("compare changed without a write");

    run_write_a: assert property ( // [RULE4]
        wr_ctl |=> (run_control_reg == $past(I_WDATA[CTL_RUN_BIT])))
        else $error("run bit write did not land");

    status_set_a: assert property ( // [RULE3]
        (I_CE && hit) |=> irq_status[IRQ_MATCH_BIT])
        else $error("match did not set status");

    status_clr_a: assert property ( // [RULE3]
        (rd_sts && !hit) |=> !irq_status[IRQ_MATCH_BIT])
        else $error("status read did not clear");

    rdata_idle_a: assert property ( // [RULE9]
        (I_CE && !I_RD) |=> (O_RDATA == 8'h00))
        else $error("read data not zero outside read cycle");

    match_cv: cover property (hit ##1 O_MATCH);
    capture_rd_cv: cover property (
        (I_RD && I_ADDR == OFS_COUNT_CAPTURE && run_control_reg));
    irq_cv: cover property ($rose(O_IRQ));
    irq_clear_cv: cover property (O_IRQ ##1 rd_sts ##1 !O_IRQ);

endmodule // itc_timer

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import itc_pkg::*;

    logic              I_CLK;
    logic              I_NRST;
    logic              I_CE;
    logic [ADDR_W-1:0] I_ADDR;
    logic [DATA_W-1:0] I_WDATA;
    logic              I_WR;
    logic              I_RD;
    logic [DATA_W-1:0] O_RDATA;
    logic              O_MATCH;
    logic              O_IRQ;
    int                miscompares = 0;
    int                checks = 0;
    int                n;
    logic [31:0]       seed = 32'h9fa9_bf1d;
    logic [7:0]        cmp;
    logic              rd_seen = 1'b0;
    logic [7:0]        exp_q[$];
    logic [7:0]        msk_q[$];

    itc_timer dut (
        .I_CLK   (I_CLK),
        .I_NRST  (I_NRST),
        .I_CE    (I_CE),
        .I_ADDR  (I_ADDR),
        .I_WDATA (I_WDATA),
        .I_WR    (I_WR),
        .I_RD    (I_RD),
        .O_RDATA (O_RDATA),
        .O_MATCH (O_MATCH),
        .O_IRQ   (O_IRQ)
    );

    initial I_CLK = 1'b0;
    always #5 I_CLK = ~I_CLK;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // A gap cycle after each strobe keeps one assignment per signal per step
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        I_ADDR  <= a;
        I_WDATA <= d;
        I_WR    <= 1'b1;
        @(posedge I_CLK);
        I_WR <= 1'b0;
        @(posedge I_CLK);
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [7:0] e,
                          input logic [7:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        I_ADDR <= a;
        I_RD   <= 1'b1;
        @(posedge I_CLK);
        I_RD <= 1'b0;
        @(posedge I_CLK);
    endtask

    task automatic irq_is(input logic v);
        @(negedge I_CLK);
        check({7'h00, O_IRQ}, {7'h00, v});
        @(posedge I_CLK);
    endtask

    // Counts falling edges until the match pulse; none means no match at all
    task automatic wait_match(input int lim, input bit none, output int k);
        k = 0;
        while (k < lim && O_MATCH !== 1'b1)
        begin
            @(negedge I_CLK);
            k++;
        end
        if (none)
            check({7'h00, O_MATCH}, 8'h00);
        else if (O_MATCH !== 1'b1)
        begin
            check(8'h00, 8'h01);
            end_sim();
        end
        else
        begin
            @(negedge I_CLK);
            check({7'h00, O_MATCH}, 8'h00);
        end
        @(posedge I_CLK);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Read data is due in the cycle after an accepted read strobe only
    always @(posedge I_CLK)
        rd_seen <= I_RD && I_CE;

    always @(negedge I_CLK)
    begin
        if (rd_seen)
        begin
            check(O_RDATA & msk_q[0], exp_q[0] & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    initial
    begin
        repeat (95000) @(posedge I_CLK);
        miscompares++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        I_NRST  = 1'b0;
        I_CE    = 1'b1;
        I_ADDR  = 8'h00;
        I_WDATA = 8'h00;
        I_WR    = 1'b0;
        I_RD    = 1'b0;
        repeat (5) @(posedge I_CLK);
        I_NRST <= 1'b1;
        @(posedge I_CLK);
        bus_rd(OFS_COMPARE_PERIOD, 8'hFF, 8'hFF);
        bus_rd(OFS_COUNT_CAPTURE, 8'hFF, 8'hFF);
        bus_rd(OFS_TIMER_CONTROL, 8'h00, 8'h5F);
        bus_rd(OFS_IRQ_STATUS, 8'h00, 8'hFF);
        bus_rd(OFS_IRQ_MASK, 8'h00, 8'hFF);
        bus_rd(OFS_CLOCK_CONFIG, 8'h00, 8'hFF);
        bus_rd(8'h30, 8'h00, 8'hFF);
        seed = xorshift(seed);
        bus_wr(OFS_COUNT_CAPTURE, seed[7:0]);
        bus_rd(OFS_COUNT_CAPTURE, 8'hFF, 8'hFF);
        I_CE <= 1'b0;
        bus_wr(OFS_COMPARE_PERIOD, 8'h02);
        I_CE <= 1'b1;
        bus_rd(OFS_COMPARE_PERIOD, 8'hFF, 8'hFF);
        // Period of two ticks for select codes 0..6, code 7 must give no match; second gap is exact
        bus_wr(OFS_COMPARE_PERIOD, 8'h02);
        for (int s = 0; s < 8; s++)
        begin
            bus_wr(OFS_TIMER_CONTROL, 8'h00);
            bus_wr(OFS_TIMER_CONTROL, {4'b0001, s[2:0], 1'b0});
            if (s == 7)
                wait_match(2000, 1'b1, n);
            else
            begin
                wait_match(2 << (14 - s), 1'b0, n);
                wait_match(2 << (14 - s), 1'b0, n);
                check({7'h00, n == (2 << (13 - s)) - 1}, 8'h01);
            end
        end
        bus_wr(OFS_TIMER_CONTROL, 8'h00);
        bus_wr(OFS_CLOCK_CONFIG, 8'h01);
        bus_wr(OFS_TIMER_CONTROL, 8'h1C);
        wait_match(1100, 1'b0, n);
        wait_match(1100, 1'b0, n);
        check({7'h00, n == 511}, 8'h01);
        bus_wr(OFS_TIMER_CONTROL, 8'h00);
        bus_wr(OFS_CLOCK_CONFIG, 8'h00);
        // Interrupt: masked, unmasked, cleared by status read
        irq_is(1'b0);
        bus_wr(OFS_IRQ_MASK, 8'h01);
        irq_is(1'b1);
        bus_rd(OFS_IRQ_STATUS, 8'h01, 8'hFF);
        irq_is(1'b0);
        seed = xorshift(seed);
        cmp = 8'h03 + {6'h00, seed[1:0]};
        bus_wr(OFS_COMPARE_PERIOD, cmp);
        bus_wr(OFS_TIMER_CONTROL, 8'h5C);
        wait_match(1000, 1'b0, n);
        irq_is(1'b1);
        bus_rd(OFS_COUNT_CAPTURE, cmp - 8'h01, 8'hFF);
        bus_rd(OFS_IRQ_STATUS, 8'h01, 8'hFF);
        irq_is(1'b0);
        repeat (130) @(posedge I_CLK);
        bus_rd(OFS_COUNT_CAPTURE, 8'h01, 8'hFF);
        // Stopping mid-count must clear the counter
        bus_wr(OFS_TIMER_CONTROL, 8'h4C);
        repeat (200) @(posedge I_CLK);
        bus_wr(OFS_TIMER_CONTROL, 8'h5C);
        wait_match(1000, 1'b0, n);
        check({7'h00, n >= cmp * 128 - 2 && n <= cmp * 128 + 1},
              8'h01);
        end_sim();
    end

endmodule // tb_top
